// >>> common/hotplug_pkg.sv
package hotplug_pkg;

  localparam logic [9:0]  IDX_SLOT_CTRL   = 10'h058;
  localparam logic [9:0]  IDX_SLOT_STATUS = 10'h05a;
  localparam logic [9:0]  IDX_DEVCAP2     = 10'h064;
  localparam logic [9:0]  IDX_DEVCTL2     = 10'h068;
  localparam logic [9:0]  IDX_IRQ_STATUS  = 10'h080;
  localparam logic [9:0]  IDX_IRQ_MASK    = 10'h081;
  localparam logic [9:0]  IDX_CONFIG      = 10'h082;

  localparam int EV_BUTTON   = 0;
  localparam int EV_PFAULT   = 1;
  localparam int EV_LATCH    = 2;
  localparam int EV_PRESENCE = 3;
  localparam int EV_CMD      = 4;
  localparam int EV_LINK     = 5;
  localparam int ST_LINK_CHG = 8;
  localparam int FWD_BIT     = 5;

  localparam int SCTL_HOTPLUG_INTERRUPT_ENABLE    = 5;
  localparam int SCTL_EIC     = 11;
  localparam int SCTL_LINK_EN = 12;
  localparam logic [15:0] SCTL_STORE_MASK = 16'h17ff;

  localparam int CFG_LOCK      = 0;
  localparam int CFG_SLOT_IMPL = 1;
  localparam int CFG_UPSTREAM  = 2;
  localparam int CFG_EXP_EN    = 3;
  localparam int CFG_GPIO_MAP  = 4;
  localparam int CFG_ILOCK     = 5;
  localparam logic [5:0] CFG_RESET = 6'h0a;

  typedef struct packed {
    logic button_press;
    logic power_fault;
    logic latch_open;
    logic presence;
    logic interlock;
    logic link_active;
  } slot_in_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [5:0]  ev;
    logic [15:0] slot_ctrl;
    logic        fwd_sup;
    logic        fwd_en;
    logic [5:0]  cfg;
    logic [5:0]  irq_stat;
    logic [5:0]  irq_mask;
    logic        irq;
  } regs_t;

  localparam regs_t REGS_RESET = '{ack: 1'b0, rdata: 32'h0, ev: 6'h0, slot_ctrl: 16'h0, fwd_sup: 1'b1,
                                   fwd_en: 1'b0, cfg: CFG_RESET, irq_stat: 6'h0, irq_mask: 6'h0, irq: 1'b0};

  typedef enum logic {TRK_IDLE, TRK_RUN} trk_state_t;

  typedef struct packed {
    trk_state_t  state;
    logic [3:0]  pending;
    logic        req;
    logic [1:0]  group;
    logic        done;
  } trk_t;

  typedef struct packed {
    logic       armed;
    logic [2:0] prev;
  } chg_t;

endpackage

// >>> dv/expander_model.sv
`timescale 1ns/1ps
module expander_model (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       exp_req,
  input  wire logic [1:0] exp_group,
  input  wire logic [3:0] lat,
  output logic            exp_ack,
  output logic      [3:0] n_txn,
  output logic      [7:0] grp_log
);
  logic [3:0] cnt;

  // Stalls lat cycles per transfer so a command can be caught in flight
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      exp_ack <= 1'b0;
      cnt     <= 4'h0;
      n_txn   <= 4'h0;
      grp_log <= 8'h00;
    end else if (exp_ack) begin
      exp_ack <= 1'b0;
      cnt     <= 4'h0;
    end else if (exp_req && cnt >= lat) begin
      exp_ack <= 1'b1;
      n_txn   <= n_txn + 4'h1;
      grp_log <= {grp_log[5:0], exp_group};
    end else if (exp_req) begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// >>> dv/hotplug_slot_status_regs_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module hotplug_slot_status_regs_tb_top;
  localparam logic [11:0] A_CTL  = {hotplug_pkg::IDX_SLOT_CTRL, 2'b00};
  localparam logic [11:0] A_ST   = {hotplug_pkg::IDX_SLOT_STATUS, 2'b00};
  localparam logic [11:0] A_CAP  = {hotplug_pkg::IDX_DEVCAP2, 2'b00};
  localparam logic [11:0] A_CTL2 = {hotplug_pkg::IDX_DEVCTL2, 2'b00};
  localparam logic [11:0] A_IRQ  = {hotplug_pkg::IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] A_MSK  = {hotplug_pkg::IDX_IRQ_MASK, 2'b00};
  localparam logic [11:0] A_CFG  = {hotplug_pkg::IDX_CONFIG, 2'b00};
  logic                   sys_clk, arst_n, we_i, cyc_i, stb_i, ack_o, exp_ack, exp_req, irq;
  logic [11:0]            adr_i;
  logic [31:0]            dat_i, dat_o, r;
  logic [3:0]             sel_i, lat, n_txn;
  logic [1:0]             exp_group;
  logic [15:0]            slot_ctrl_out;
  logic [7:0]             grp_log;
  logic [63:0]            note;
  logic [63:0]            expq[$];
  hotplug_pkg::slot_in_t  slot_in;
  int                     num_errors, n_compared, i, n;
  int                     evb[5] = '{0, 1, 2, 3, 8};

  hotplug_slot_status_regs dut (.sys_clk, .arst_n, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i, .stb_i,
    .ack_o, .slot_in, .exp_ack, .exp_req, .exp_group, .slot_ctrl_out, .irq);
  expander_model exp_far (.sys_clk, .arst_n, .exp_req, .exp_group, .lat, .exp_ack, .n_txn, .grp_log);

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic finish_test();
    $display("compared=%0d mismatches=%0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Holds the request until ack is sampled; a read leaves its note for the monitor
  task automatic wb(input logic [11:0] a, input logic [31:0] d, input logic w, input logic [3:0] s,
                    input logic [31:0] e, input logic [31:0] m);
    int k;
    if (!w) begin
      expq.push_back({m, e});
    end
    @(posedge sys_clk);
    adr_i <= a;
    dat_i <= d;
    we_i  <= w;
    sel_i <= s;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge sys_clk);
      if (ack_o === 1'b1) break;
    end
    if (k == 50) begin
      num_errors++;
      finish_test();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    wb(a, d, 1'b1, s, 32'h0, 32'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    wb(a, 32'h0, 1'b0, 4'hf, e, m);
  endtask

  task automatic trig(input int b);
    @(posedge sys_clk);
    case (b)
      0: slot_in.button_press <= 1'b1;
      1: slot_in.power_fault <= 1'b1;
      2: slot_in.latch_open <= ~slot_in.latch_open;
      3: slot_in.presence <= ~slot_in.presence;
      default: slot_in.link_active <= ~slot_in.link_active;
    endcase
    @(posedge sys_clk);
    slot_in.button_press <= 1'b0;
    slot_in.power_fault  <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  always @(posedge sys_clk) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      if (expq.size() == 0) begin
        `CHK(dat_o, 32'h0)
      end else begin
        note = expq.pop_front();
        `CHK(dat_o & note[63:32], note[31:0] & note[63:32])
      end
    end
  end

  initial begin
    n = $urandom(32'h0db30a7c);
    {arst_n, cyc_i, stb_i, we_i, adr_i, dat_i, lat} = '0;
    sel_i = 4'hf;
    slot_in = '0;
    slot_in.presence = 1'b1;
    slot_in.interlock = 1'b1;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(A_ST, 32'h40);
    rd(A_CAP, 32'h20);
    rd(12'hffc, 32'h0);
    `CHK(irq, 1'b0)
    $display("test reset done");
    foreach (evb[k]) begin
      wr(A_ST, 32'h11f);
      trig(evb[k]);
      rd(A_ST, 32'h1 << evb[k], 32'h11f);
      wr(A_ST, 32'h0);
      rd(A_ST, 32'h1 << evb[k], 32'h11f);
      wr(A_ST, 32'h1 << evb[k]);
      rd(A_ST, 32'h0, 32'h11f);
      rd(A_ST, {slot_in.presence, slot_in.latch_open, 5'h0}, 32'h60);
    end
    r = $urandom & 32'hfffffe00;
    wr(A_ST, r);
    rd(A_ST, 32'h0, 32'hfffffe00);
    $display("test events done");
    wr(A_CTL, 32'h21);
    wr(A_MSK, 32'h01);
    wr(A_ST, 32'h11f);
    trig(0);
    for (i = 0; i < 5 && irq !== 1'b1; i++) @(posedge sys_clk);
    `CHK(irq, 1'b1)
    rd(A_IRQ, 32'h01, 32'h3f);
    repeat (3) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    wr(A_MSK, 32'h0);
    wr(A_ST, 32'h11f);
    trig(0);
    `CHK(irq, 1'b0)
    rd(A_IRQ, 32'h01, 32'h3f);
    wr(A_CTL, 32'h01);
    wr(A_ST, 32'h11f);
    trig(0);
    rd(A_IRQ, 32'h0, 32'h3f);
    $display("test interrupt done");
    wr(A_ST, 32'h11f);
    lat <= 4'(8 + $urandom % 8);
    wr(A_CTL, 32'h0341);
    rd(A_ST, 32'h0, 32'h10);
    for (i = 0; i < 300 && n_txn !== 4'h2; i++) @(posedge sys_clk);
    `CHK(n_txn, 4'h2)
    `CHK(grp_log[3:0], 4'h1)
    repeat (4) @(posedge sys_clk);
    rd(A_ST, 32'h10, 32'h10);
    `CHK(slot_ctrl_out, 16'h0341)
    lat <= 4'h0;
    wr(A_ST, 32'h10);
    wr(A_CTL, 32'h0341);
    rd(A_ST, 32'h10, 32'h10);
    wr(A_ST, 32'h10);
    wr(A_CTL, 32'h0b41);
    for (i = 0; i < 300 && n_txn !== 4'h3; i++) @(posedge sys_clk);
    `CHK(n_txn, 4'h3)
    `CHK(grp_log[1:0], 2'h3)
    `CHK(slot_ctrl_out, 16'h0341)
    repeat (4) @(posedge sys_clk);
    rd(A_ST, 32'h10, 32'h10);
    $display("test command done");
    wr(A_CTL2, 32'h20);
    rd(A_CTL2, 32'h20);
    wr(A_CAP, 32'h0, 4'he);
    rd(A_CAP, 32'h20);
    wr(A_CAP, 32'h0);
    rd(A_CAP, 32'h0);
    rd(A_CTL2, 32'h0);
    wr(A_CAP, 32'h20);
    wr(A_CFG, 32'h0b);
    wr(A_CAP, 32'h0);
    rd(A_CAP, 32'h20);
    wr(A_CFG, 32'h0e);
    rd(A_CAP, 32'h0);
    rd(A_ST, 32'h0, 32'h40);
    wr(A_CFG, 32'h08);
    rd(A_ST, 32'h40, 32'h40);
    wr(A_CFG, 32'h2a);
    rd(A_ST, 32'h80, 32'h80);
    wr(A_CFG, 32'h3a);
    rd(A_ST, 32'h0, 32'h80);
    wr(A_CFG, 32'h22);
    rd(A_ST, 32'h0, 32'h80);
    $display("test config done");
    repeat (3) @(posedge sys_clk);
    finish_test();
  end
endmodule

// >>> verilog/change_detect.sv
`timescale 1ns/1ps
module change_detect (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic [2:0] level,
  output logic      [2:0] changed
);

  hotplug_pkg::chg_t r;
  hotplug_pkg::chg_t next_r;

  // No change is reported before the first sample after reset
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_bit
      assign changed[i] = r.armed & (level[i] ^ r.prev[i]);
    end
  endgenerate

  always_comb begin
    next_r       = r;
    next_r.armed = 1'b1;
    next_r.prev  = level;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule

// >>> verilog/cmd_tracker.sv
`timescale 1ns/1ps
module cmd_tracker (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       start,
  input  wire logic [3:0] groups,
  input  wire logic       exp_ack,
  output logic            exp_req,
  output logic      [1:0] exp_group,
  output logic            done
);

  hotplug_pkg::trk_t r;
  hotplug_pkg::trk_t next_r;

  function automatic logic [1:0] first_set(input logic [3:0] v);
    first_set = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      if (v[k]) begin
        first_set = 2'(k);
      end
    end
  endfunction

  assign exp_req   = r.req;
  assign exp_group = r.group;
  assign done      = r.done;

  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    if (r.req && exp_ack) begin
      next_r.pending[r.group] = 1'b0;
      next_r.req              = 1'b0;
    end
    // A write during a running command folds into it; completion waits for all
    if (start) begin
      next_r.pending = next_r.pending | groups;
      next_r.state   = hotplug_pkg::TRK_RUN;
    end
    case (r.state)
      hotplug_pkg::TRK_IDLE: begin
        next_r.req = 1'b0;
      end
      hotplug_pkg::TRK_RUN: begin
        if (!r.req && next_r.pending != 4'h0) begin
          next_r.req   = 1'b1;
          next_r.group = first_set(next_r.pending);
        end else if (!r.req && !start && next_r.pending == 4'h0) begin
          next_r.done  = 1'b1;
          next_r.state = hotplug_pkg::TRK_IDLE;
        end
      end
      default: begin
        next_r.state = hotplug_pkg::TRK_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{state: hotplug_pkg::TRK_IDLE, pending: 4'h0, req: 1'b0, group: 2'h0, done: 1'b0};
    end else begin
      r <= next_r;
    end
  end

endmodule

// >>> verilog/hotplug_slot_status_regs.sv
`timescale 1ns/1ps
module hotplug_slot_status_regs (
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  input  wire logic [11:0]          adr_i,
  input  wire logic [31:0]          dat_i,
  output logic      [31:0]          dat_o,
  input  wire logic                 we_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  output logic                      ack_o,
  input  wire hotplug_pkg::slot_in_t slot_in,
  input  wire logic                 exp_ack,
  output logic                      exp_req,
  output logic      [1:0]           exp_group,
  output logic      [15:0]          slot_ctrl_out,
  output logic                      irq
);

  hotplug_pkg::regs_t r;
  hotplug_pkg::regs_t next_r;
  logic [2:0]         chg;
  logic               cmd_done;
  logic               cmd_start;
  logic [3:0]         cmd_groups;

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = 32'h0;
    for (int k = 0; k < 4; k++) begin
      lane_mask[8*k +: 8] = {8{sel[k]}};
    end
  endfunction

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [31:0] m
  );
    merge = (old & ~m) | (wd & m);
  endfunction

  change_detect u_change (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .level   ({slot_in.link_active, slot_in.presence, slot_in.latch_open}),
    .changed (chg)
  );

  cmd_tracker u_tracker (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .start     (cmd_start),
    .groups    (cmd_groups),
    .exp_ack   (exp_ack),
    .exp_req   (exp_req),
    .exp_group (exp_group),
    .done      (cmd_done)
  );

  assign dat_o         = r.rdata;
  assign ack_o         = r.ack;
  assign slot_ctrl_out = r.slot_ctrl;
  assign irq           = r.irq;

  always_comb begin
    logic        acc;
    logic        wr;
    logic        rd;
    logic [9:0]  idx;
    logic [31:0] bm;
    logic [31:0] w;
    logic [31:0] rw;
    logic [15:0] m16;
    logic [5:0]  sets;
    logic [5:0]  clr;
    logic [5:0]  en;
    logic        presence_state;
    logic        interlock_status;
    logic        sup;
    acc    = cyc_i & stb_i & ~r.ack;
    wr     = acc & we_i;
    rd     = acc & ~we_i;
    idx    = adr_i[11:2];
    bm     = lane_mask(sel_i);
    w      = 32'h0;
    m16    = bm[15:0] & hotplug_pkg::SCTL_STORE_MASK;
    clr    = 6'h0;
    rw     = 32'h0;
    presence_state    = 1'b0;
    interlock_status    = 1'b0;
    sup    = 1'b0;
    sets   = 6'h0;
    en     = 6'h0;
    next_r = r;

    // Live status bits are sampled when the read is taken
    if (r.cfg[hotplug_pkg::CFG_UPSTREAM]) begin
      presence_state = 1'b0;
    end else if (r.cfg[hotplug_pkg::CFG_SLOT_IMPL]) begin
      presence_state = slot_in.presence;
    end else begin
      presence_state = 1'b1;
    end
    interlock_status = r.cfg[hotplug_pkg::CFG_ILOCK] & slot_in.interlock;
    if (r.cfg[hotplug_pkg::CFG_GPIO_MAP] || !r.cfg[hotplug_pkg::CFG_EXP_EN]) begin
      interlock_status = 1'b0;
    end
    sup = r.fwd_sup & ~r.cfg[hotplug_pkg::CFG_UPSTREAM];

    // Reserved and unmapped locations read zero
    case (idx)
      hotplug_pkg::IDX_SLOT_STATUS: begin
        rw = {23'h0, r.ev[hotplug_pkg::EV_LINK], interlock_status, presence_state, slot_in.latch_open, r.ev[4:0]};
      end
      hotplug_pkg::IDX_SLOT_CTRL: begin
        rw = {16'h0, r.slot_ctrl};
      end
      hotplug_pkg::IDX_DEVCAP2: begin
        rw = {26'h0, sup, 5'h0};
      end
      hotplug_pkg::IDX_DEVCTL2: begin
        rw = {26'h0, r.fwd_en, 5'h0};
      end
      hotplug_pkg::IDX_IRQ_STATUS: begin
        rw = {26'h0, r.irq_stat};
      end
      hotplug_pkg::IDX_IRQ_MASK: begin
        rw = {26'h0, r.irq_mask};
      end
      hotplug_pkg::IDX_CONFIG: begin
        rw = {26'h0, r.cfg};
      end
      default: begin
        rw = 32'h0;
      end
    endcase

    next_r.ack   = acc;
    next_r.rdata = rd ? rw : 32'h0;

    // Slot control: a write to byte 0 or 1 starts a command, or joins a running one, whatever fields it touches
    cmd_start  = wr && idx == hotplug_pkg::IDX_SLOT_CTRL && (|sel_i[1:0]);
    cmd_groups = 4'h0;
    if (cmd_start) begin
      next_r.slot_ctrl = (r.slot_ctrl & ~m16) | (dat_i[15:0] & m16);
      cmd_groups[0]    = next_r.slot_ctrl[7:6] != r.slot_ctrl[7:6];
      cmd_groups[1]    = next_r.slot_ctrl[9:8] != r.slot_ctrl[9:8];
      cmd_groups[2]    = next_r.slot_ctrl[10] != r.slot_ctrl[10];
      cmd_groups[3]    = dat_i[hotplug_pkg::SCTL_EIC] & bm[hotplug_pkg::SCTL_EIC];
    end

    // Write-one-to-clear; a zero leaves the flag, a same-cycle event wins
    if (wr && idx == hotplug_pkg::IDX_SLOT_STATUS) begin
      clr = {dat_i[hotplug_pkg::ST_LINK_CHG], dat_i[4:0]} & {bm[hotplug_pkg::ST_LINK_CHG], bm[4:0]};
    end
    sets[hotplug_pkg::EV_BUTTON]   = slot_in.button_press;
    sets[hotplug_pkg::EV_PFAULT]   = slot_in.power_fault;
    sets[hotplug_pkg::EV_LATCH]    = chg[0];
    sets[hotplug_pkg::EV_PRESENCE] = chg[1];
    sets[hotplug_pkg::EV_CMD]      = cmd_done;
    sets[hotplug_pkg::EV_LINK]     = chg[2];
    next_r.ev = (r.ev & ~clr) | sets;

    // Configuration straps held in a register of their own
    if (wr && idx == hotplug_pkg::IDX_CONFIG) begin
      w          = merge({26'h0, r.cfg}, dat_i, bm);
      next_r.cfg = w[5:0];
    end

    if (wr && idx == hotplug_pkg::IDX_DEVCAP2 && !r.cfg[hotplug_pkg::CFG_LOCK]
        && !r.cfg[hotplug_pkg::CFG_UPSTREAM]) begin
      w              = merge({26'h0, r.fwd_sup, 5'h0}, dat_i, bm);
      next_r.fwd_sup = w[hotplug_pkg::FWD_BIT];
    end

    if (wr && idx == hotplug_pkg::IDX_DEVCTL2) begin
      w             = merge({26'h0, r.fwd_en, 5'h0}, dat_i, bm);
      next_r.fwd_en = w[hotplug_pkg::FWD_BIT];
    end
    // Enable can never outlive support, even across a lock or port change
    next_r.fwd_en = next_r.fwd_en & next_r.fwd_sup & ~next_r.cfg[hotplug_pkg::CFG_UPSTREAM];

    if (wr && idx == hotplug_pkg::IDX_IRQ_MASK) begin
      w               = merge({26'h0, r.irq_mask}, dat_i, bm);
      next_r.irq_mask = w[5:0];
    end

    // Only a flag that newly rises counts, so a held fault does not refire
    en = {r.slot_ctrl[hotplug_pkg::SCTL_LINK_EN], r.slot_ctrl[4:0]}
         & {6{r.slot_ctrl[hotplug_pkg::SCTL_HOTPLUG_INTERRUPT_ENABLE]}};
    if (rd && idx == hotplug_pkg::IDX_IRQ_STATUS) begin
      next_r.irq_stat = 6'h0;
    end
    next_r.irq_stat = next_r.irq_stat | (next_r.ev & ~r.ev & en);
    next_r.irq      = |(next_r.irq_stat & next_r.irq_mask);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= hotplug_pkg::REGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_status_read;
    cyc_i && stb_i && !we_i && !ack_o && adr_i[11:2] == hotplug_pkg::IDX_SLOT_STATUS ##1 ack_o;
  endsequence

  sequence s_latch_toggle;
    !slot_in.latch_open ##1 slot_in.latch_open;
  endsequence

  sequence s_link_toggle;
    !slot_in.link_active ##1 slot_in.link_active;
  endsequence

  property p_button_set;
    slot_in.button_press |=> r.ev[hotplug_pkg::EV_BUTTON] [*2];
  endproperty
  a_button_set: assert property (p_button_set) else $error("button flag not held");

  property p_fault_set;
    slot_in.power_fault |=> r.ev[hotplug_pkg::EV_PFAULT];
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault flag not set");

  property p_latch_chg;
    s_latch_toggle |=> r.ev[hotplug_pkg::EV_LATCH];
  endproperty
  a_latch_chg: assert property (p_latch_chg) else $error("latch change missed");

  property p_pres_chg;
    $changed(slot_in.presence) && u_change.r.armed |=> r.ev[hotplug_pkg::EV_PRESENCE];
  endproperty
  a_pres_chg: assert property (p_pres_chg) else $error("presence change missed");

  property p_link_chg;
    s_link_toggle |=> r.ev[hotplug_pkg::EV_LINK];
  endproperty
  a_link_chg: assert property (p_link_chg) else $error("link change missed");

  property p_cmd_after_exp;
    $rose(r.ev[hotplug_pkg::EV_CMD]) |-> !$past(exp_req);
  endproperty
  a_cmd_after_exp: assert property (p_cmd_after_exp) else $error("completion during transfer");

  property p_cmd_set;
    cmd_done |=> r.ev[hotplug_pkg::EV_CMD];
  endproperty
  a_cmd_set: assert property (p_cmd_set) else $error("completion flag not set");

  property p_pds_up;
    s_status_read |-> !$past(r.cfg[hotplug_pkg::CFG_UPSTREAM]) || !dat_o[6];
  endproperty
  a_pds_up: assert property (p_pds_up) else $error("upstream presence not zero");

  property p_pds_noslot;
    s_status_read |-> $past(r.cfg[hotplug_pkg::CFG_UPSTREAM] || r.cfg[hotplug_pkg::CFG_SLOT_IMPL]) || dat_o[6];
  endproperty
  a_pds_noslot: assert property (p_pds_noslot) else $error("no-slot presence not one");

  property p_eis_gpio;
    s_status_read |-> !$past(r.cfg[hotplug_pkg::CFG_GPIO_MAP]) || !dat_o[7];
  endproperty
  a_eis_gpio: assert property (p_eis_gpio) else $error("interlock not zero");

  property p_reserved;
    s_status_read |-> dat_o[31:9] == 23'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_fwd_en_zero;
    !r.fwd_sup || r.cfg[hotplug_pkg::CFG_UPSTREAM] |-> !r.fwd_en;
  endproperty
  a_fwd_en_zero: assert property (p_fwd_en_zero) else $error("enable without support");

  property p_fwd_lock;
    r.cfg[hotplug_pkg::CFG_LOCK] |=> $stable(r.fwd_sup);
  endproperty
  a_fwd_lock: assert property (p_fwd_lock) else $error("locked bit changed");

  property p_irq_hotplug_interrupt_enable;
    !r.slot_ctrl[hotplug_pkg::SCTL_HOTPLUG_INTERRUPT_ENABLE] |=> (r.irq_stat & ~$past(r.irq_stat)) == 6'h0;
  endproperty
  a_irq_hotplug_interrupt_enable: assert property (p_irq_hotplug_interrupt_enable) else $error("interrupt without enable");

  // Status word write strobe, shared by the flag hold checks
  logic st_wr;
  assign st_wr = cyc_i && stb_i && we_i && !ack_o && adr_i[11:2] == hotplug_pkg::IDX_SLOT_STATUS;

  property p_button_hold;
    r.ev[hotplug_pkg::EV_BUTTON] && !(st_wr && dat_i[0] && sel_i[0]) |=> r.ev[hotplug_pkg::EV_BUTTON];
  endproperty
  a_button_hold: assert property (p_button_hold) else $error("button flag lost");

  property p_button_clear;
    st_wr && dat_i[0] && sel_i[0] && !slot_in.button_press |=> !r.ev[hotplug_pkg::EV_BUTTON];
  endproperty
  a_button_clear: assert property (p_button_clear) else $error("button flag not cleared");

  property p_fault_hold;
    r.ev[hotplug_pkg::EV_PFAULT] && !(st_wr && dat_i[1] && sel_i[0]) |=> r.ev[hotplug_pkg::EV_PFAULT];
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault flag lost");

  property p_latch_hold;
    r.ev[hotplug_pkg::EV_LATCH] && !(st_wr && dat_i[2] && sel_i[0]) |=> r.ev[hotplug_pkg::EV_LATCH];
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch flag lost");

  property p_pres_hold;
    r.ev[hotplug_pkg::EV_PRESENCE] && !(st_wr && dat_i[3] && sel_i[0]) |=> r.ev[hotplug_pkg::EV_PRESENCE];
  endproperty
  a_pres_hold: assert property (p_pres_hold) else $error("presence flag lost");

  property p_cmd_hold;
    r.ev[hotplug_pkg::EV_CMD] && !(st_wr && dat_i[4] && sel_i[0]) |=> r.ev[hotplug_pkg::EV_CMD];
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("completion flag lost");

  property p_link_hold;
    r.ev[hotplug_pkg::EV_LINK] && !(st_wr && dat_i[8] && sel_i[1]) |=> r.ev[hotplug_pkg::EV_LINK];
  endproperty
  a_link_hold: assert property (p_link_hold) else $error("link flag lost");

  property p_latch_state;
    s_status_read |-> dat_o[5] == $past(slot_in.latch_open);
  endproperty
  a_latch_state: assert property (p_latch_state) else $error("latch state wrong");

  property p_pds_slot;
    s_status_read |-> $past(r.cfg[hotplug_pkg::CFG_UPSTREAM] || !r.cfg[hotplug_pkg::CFG_SLOT_IMPL])
      || dat_o[6] == $past(slot_in.presence);
  endproperty
  a_pds_slot: assert property (p_pds_slot) else $error("presence state wrong");

  property p_eis_live;
    s_status_read |-> dat_o[7] == $past(r.cfg[hotplug_pkg::CFG_ILOCK] && r.cfg[hotplug_pkg::CFG_EXP_EN]
      && !r.cfg[hotplug_pkg::CFG_GPIO_MAP] && slot_in.interlock);
  endproperty
  a_eis_live: assert property (p_eis_live) else $error("interlock state wrong");

  property p_sup_up;
    cyc_i && stb_i && !we_i && !ack_o && adr_i[11:2] == hotplug_pkg::IDX_DEVCAP2
      && r.cfg[hotplug_pkg::CFG_UPSTREAM] |=> !dat_o[hotplug_pkg::FWD_BIT];
  endproperty
  a_sup_up: assert property (p_sup_up) else $error("upstream support not zero");

  property p_exp_hold;
    exp_req && !exp_ack |=> exp_req && $stable(exp_group);
  endproperty
  a_exp_hold: assert property (p_exp_hold) else $error("expander request dropped");

endmodule
